// >>> inc/srcu_regs.vh
`ifndef SRCU_REGS_VH
`define SRCU_REGS_VH

// Register byte offsets
`define SRCU_OFF_STATUS    8'h00
`define SRCU_OFF_SOFT_RESET_TRIGGER_BIT     8'h04
`define SRCU_OFF_UNLOCK    8'h08
`define SRCU_OFF_IRQ_STAT  8'h0c
`define SRCU_OFF_IRQ_CLR   8'h10
`define SRCU_OFF_IRQ_EN    8'h14

// Reset status field positions and the trigger register bit position
`define SRCU_BIT_POR       0
`define SRCU_BIT_BOR       1
`define SRCU_BIT_IDLE      2
`define SRCU_BIT_SLEEP     3
`define SRCU_BIT_WATCHDOG_TIMEOUT_FLAG      4
`define SRCU_BIT_SWR       6
`define SRCU_BIT_EXTERNAL_PIN_RESET_FLAG      7
`define SRCU_BIT_VREG      8
`define SRCU_BIT_CMR       9
`define SRCU_BIT_SOFT_RESET_TRIGGER_BIT     0
`define SRCU_BIT_RSVD      5

// Source positions in the gathered level vector
`define SRCU_NUM_SRC       6
`define SRCU_SRC_PIN       0
`define SRCU_SRC_WDT       1
`define SRCU_SRC_BOR       2
`define SRCU_SRC_CMR       3
`define SRCU_SRC_SLP       4
`define SRCU_SRC_IDL       5

// Status mask of implemented bits and power-on value
`define SRCU_STATUS_MASK   10'h3df
`define SRCU_STATUS_RST    10'h003
`define SRCU_STATUS_W      10

// Unlock key words, arbitrary values
`define SRCU_KEY1          32'haa996655
`define SRCU_KEY2          32'h556699aa

// Interrupt event positions (one per cause, mirrors status layout)
`define SRCU_IRQ_W         10

// AXI responses
`define SRCU_RESP_OKAY     2'b00
`define SRCU_RESP_SLVERR   2'b10

`endif

// >>> rtl/srcu_unlock.v
`timescale 1ns/10ps
`include "srcu_regs.vh"

// Two-word key sequence opening one trigger write
module srcu_unlock (
  input  wire        clk_in,
  input  wire        srst_in,
  input  wire        key_wr_in,
  input  wire [31:0] key_data_in,
  input  wire        consume_in,
  output wire        unlocked_out
);

  localparam ST_LOCKED = 2'h0;
  localparam ST_KEY1   = 2'h1;
  localparam ST_OPEN   = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;

  // Next state of the key sequence
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_LOCKED: begin
        if (key_wr_in && key_data_in == `SRCU_KEY1) state_d = ST_KEY1;
      end
      ST_KEY1: begin
        if (key_wr_in) state_d = (key_data_in == `SRCU_KEY2) ? ST_OPEN : ST_LOCKED;
      end
      ST_OPEN: begin
        if (consume_in || key_wr_in) state_d = ST_LOCKED;
      end
      default: state_d = ST_LOCKED;
    endcase
  end

  // State register
  always @(posedge clk_in) begin
    if (srst_in) state_q <= ST_LOCKED;
    else state_q <= state_d;
  end

  assign unlocked_out = (state_q == ST_OPEN);

endmodule // srcu_unlock

// >>> rtl/srcu_top.v
`timescale 1ns/10ps
`include "srcu_regs.vh"

// Function
// - Merge all reset sources into master reset
// - Mismatch reset sets status bit 9
// - Bit 8 keeps regulator on in sleep
// - Clear pin reset sets status bit 7
// - Software reset sets status bit 6
// - Watchdog timeout sets status bit 4
// - Wake from sleep sets bit 3
// - Wake from idle sets bit 2
// - Brown-out sets bit 1, one after power-on
// - Power-on sets bit 0, reset one
// - Flags stay until software writes zero
// - Unimplemented bits read as zero
// - Writing one to trigger starts reset
// - Trigger bit clears itself in hardware
// - Trigger writes ignored while system locked
module srcu_top (
  input  wire        REF_CLK_IN,
  input  wire        SRST_IN,
  input  wire        EXTERNAL_CLEAR_PIN_IN,
  input  wire        WATCHDOG_RESET_SOURCE_IN,
  input  wire        BROWNOUT_IN,
  input  wire        CONFIG_MISMATCH_IN,
  input  wire        WAKE_SLEEP_IN,
  input  wire        WAKE_IDLE_IN,
  input  wire [31:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output wire [1:0]  S_AXI_BRESP,
  output wire        S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [31:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0]  S_AXI_RRESP,
  output wire        S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  output wire        MASTER_RESET_OUT,
  output wire        REGULATOR_STANDBY_ENABLE_OUT,
  output wire        IRQ_OUT
);

  // Power-on reset is SRST_IN; the block keeps running under other sources
  reg                     aw_hold_q;
  reg  [7:0]              aw_addr_q;
  reg                     w_hold_q;
  reg  [31:0]             w_data_q;
  reg  [3:0]              w_strb_q;
  reg                     bvalid_q;
  reg  [1:0]              bresp_q;
  reg                     arready_q;
  reg                     rvalid_q;
  reg  [31:0]             rdata_q;
  reg  [1:0]              rresp_q;
  reg  [`SRCU_STATUS_W-1:0] status_q;
  reg  [`SRCU_IRQ_W-1:0]  irq_stat_q;
  reg  [`SRCU_IRQ_W-1:0]  irq_en_q;
  reg                     irq_q;
  reg                     soft_reset_trigger_bit_q;
  reg                     mrst_q;
  reg                     awready_q;
  reg                     wready_q;
  reg                     aw_hold_d;
  reg                     w_hold_d;
  reg                     bvalid_d;

  wire                    wr_fire;
  wire                    rd_fire;
  wire                    unlocked;
  wire                    key_wr;
  wire                    trig_wr;
  wire                    stat_wr;
  wire                    aw_take;
  wire                    w_take;
  wire                    irq_clr_wr;
  wire                    irq_en_wr;
  wire [`SRCU_NUM_SRC-1:0] lvl;
  wire [`SRCU_NUM_SRC-1:0] rise;
  wire [`SRCU_STATUS_W-1:0] ev;
  wire [`SRCU_STATUS_W-1:0] stat_next;

  // True for byte offsets that hold a register
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `SRCU_OFF_STATUS) || (a == `SRCU_OFF_SOFT_RESET_TRIGGER_BIT) ||
                (a == `SRCU_OFF_UNLOCK) || (a == `SRCU_OFF_IRQ_STAT) ||
                (a == `SRCU_OFF_IRQ_CLR) || (a == `SRCU_OFF_IRQ_EN);
    end
  endfunction

  // True when a held write address selects the given offset
  function wr_hit;
    input [7:0] a;
    input [7:0] off;
    begin
      wr_hit = (a == off);
    end
  endfunction

  // Channel handshakes on registered readies
  assign aw_take = S_AXI_AWVALID && awready_q;
  assign w_take  = S_AXI_WVALID && wready_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;

  // Next hold and response state, either order
  always @* begin
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    bvalid_d  = bvalid_q;
    if (aw_take) aw_hold_d = 1'b1;
    else if (wr_fire) aw_hold_d = 1'b0;
    if (w_take) w_hold_d = 1'b1;
    else if (wr_fire) w_hold_d = 1'b0;
    if (wr_fire) bvalid_d = 1'b1;
    else if (S_AXI_BREADY) bvalid_d = 1'b0;
  end

  // Write channel capture; readies come from flip-flops
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awready_q <= !aw_hold_d && !bvalid_d; // Low while held or answer pending
      wready_q  <= !w_hold_d && !bvalid_d;
      if (aw_take) aw_addr_q <= S_AXI_AWADDR[7:0];
      if (w_take) begin
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY  = wready_q;

  // Register write decodes
  assign key_wr     = wr_fire && wr_hit(aw_addr_q, `SRCU_OFF_UNLOCK) && (&w_strb_q);
  assign stat_wr    = wr_fire && wr_hit(aw_addr_q, `SRCU_OFF_STATUS);
  assign irq_clr_wr = wr_fire && wr_hit(aw_addr_q, `SRCU_OFF_IRQ_CLR);
  assign irq_en_wr  = wr_fire && wr_hit(aw_addr_q, `SRCU_OFF_IRQ_EN);
  assign trig_wr    = wr_fire && wr_hit(aw_addr_q, `SRCU_OFF_SOFT_RESET_TRIGGER_BIT) && w_strb_q[0] &&
                      w_data_q[`SRCU_BIT_SOFT_RESET_TRIGGER_BIT] && unlocked;

  // Write response
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `SRCU_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= addr_ok(aw_addr_q) ? `SRCU_RESP_OKAY : `SRCU_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP  = bresp_q;

  // Read channel, one cycle after address
  assign rd_fire = S_AXI_ARVALID && arready_q;
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `SRCU_RESP_OKAY;
    end else if (rd_fire) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= addr_ok(S_AXI_ARADDR[7:0]) ? `SRCU_RESP_OKAY : `SRCU_RESP_SLVERR;
      case (S_AXI_ARADDR[7:0])
        `SRCU_OFF_STATUS:   rdata_q <= {22'h0, status_q & `SRCU_STATUS_MASK};
        `SRCU_OFF_IRQ_STAT: rdata_q <= {22'h0, irq_stat_q};
        `SRCU_OFF_IRQ_EN:   rdata_q <= {22'h0, irq_en_q};
        default:            rdata_q <= 32'h0000_0000;
      endcase
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  // Unlock sequencer for the trigger register
  srcu_unlock u_unlock (
    .clk_in       (REF_CLK_IN),
    .srst_in      (SRST_IN),
    .key_wr_in    (key_wr),
    .key_data_in  (w_data_q),
    .consume_in   (trig_wr),
    .unlocked_out (unlocked)
  );

  // Source levels gathered in a fixed order
  assign lvl[`SRCU_SRC_PIN] = EXTERNAL_CLEAR_PIN_IN;
  assign lvl[`SRCU_SRC_WDT] = WATCHDOG_RESET_SOURCE_IN;
  assign lvl[`SRCU_SRC_BOR] = BROWNOUT_IN;
  assign lvl[`SRCU_SRC_CMR] = CONFIG_MISMATCH_IN;
  assign lvl[`SRCU_SRC_SLP] = WAKE_SLEEP_IN;
  assign lvl[`SRCU_SRC_IDL] = WAKE_IDLE_IN;

  // One rising-edge detector per source; idle level is low
  genvar g;
  generate
    for (g = 0; g < `SRCU_NUM_SRC; g = g + 1) begin : g_edge
      reg lvl_q;
      always @(posedge REF_CLK_IN) begin
        if (SRST_IN) lvl_q <= 1'b0;
        else lvl_q <= lvl[g];
      end
      assign rise[g] = lvl[g] && !lvl_q;
    end
  endgenerate

  // Cause events, one per status bit
  assign ev[`SRCU_BIT_POR]   = 1'b0;
  assign ev[`SRCU_BIT_BOR]   = rise[`SRCU_SRC_BOR];
  assign ev[`SRCU_BIT_IDLE]  = rise[`SRCU_SRC_IDL];
  assign ev[`SRCU_BIT_SLEEP] = rise[`SRCU_SRC_SLP];
  assign ev[`SRCU_BIT_WATCHDOG_TIMEOUT_FLAG]  = rise[`SRCU_SRC_WDT];
  assign ev[`SRCU_BIT_RSVD]  = 1'b0;
  assign ev[`SRCU_BIT_SWR]   = soft_reset_trigger_bit_q;
  assign ev[`SRCU_BIT_EXTERNAL_PIN_RESET_FLAG]  = rise[`SRCU_SRC_PIN];
  assign ev[`SRCU_BIT_VREG]  = 1'b0;
  assign ev[`SRCU_BIT_CMR]   = rise[`SRCU_SRC_CMR];

  // Software write then hardware set; set wins
  assign stat_next = ((stat_wr ? w_data_q[`SRCU_STATUS_W-1:0] : status_q) | ev)
                     & `SRCU_STATUS_MASK;

  // Status register, kept across non-power-on resets
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) status_q <= `SRCU_STATUS_RST;
    else status_q <= stat_next;
  end

  // Self-clearing trigger pulse
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) soft_reset_trigger_bit_q <= 1'b0;
    else soft_reset_trigger_bit_q <= trig_wr;
  end

  // Master reset merge of all reset sources
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) mrst_q <= 1'b1;
    else mrst_q <= EXTERNAL_CLEAR_PIN_IN | WATCHDOG_RESET_SOURCE_IN | BROWNOUT_IN |
                   CONFIG_MISMATCH_IN | soft_reset_trigger_bit_q;
  end

  assign MASTER_RESET_OUT             = mrst_q;
  assign REGULATOR_STANDBY_ENABLE_OUT = status_q[`SRCU_BIT_VREG];

  // Interrupt status, enable and level output
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      irq_stat_q <= {`SRCU_IRQ_W{1'b0}};
      irq_en_q   <= {`SRCU_IRQ_W{1'b0}};
      irq_q      <= 1'b0;
    end else begin
      // Event wins over a same-cycle clear
      irq_stat_q <= (irq_clr_wr ? (irq_stat_q & ~w_data_q[`SRCU_IRQ_W-1:0]) : irq_stat_q) | ev;
      // Enable keeps only implemented positions
      if (irq_en_wr) irq_en_q <= w_data_q[`SRCU_IRQ_W-1:0] & `SRCU_STATUS_MASK;
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  assign IRQ_OUT = irq_q;

endmodule // srcu_top

// >>> test/srcu_props.sv
`timescale 1ns/10ps
// Bus timing, reset merging and reserved read bits
module srcu_props (
  input wire        REF_CLK_IN,
  input wire        SRST_IN,
  input wire        EXTERNAL_CLEAR_PIN_IN,
  input wire        WATCHDOG_RESET_SOURCE_IN,
  input wire        BROWNOUT_IN,
  input wire        CONFIG_MISMATCH_IN,
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire        S_AXI_WVALID,
  input wire        S_AXI_WREADY,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire [31:0] S_AXI_ARADDR,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0]  S_AXI_RRESP,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire        MASTER_RESET_OUT
);
  // Any source level, read address taken
  wire src = EXTERNAL_CLEAR_PIN_IN | WATCHDOG_RESET_SOURCE_IN | BROWNOUT_IN | CONFIG_MISMATCH_IN;
  wire ar = S_AXI_ARVALID & S_AXI_ARREADY;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);
  chk_src_merge: assert property (src |=> MASTER_RESET_OUT)
    else $error("master reset missed a source");
  chk_quiet_release: assert property ((!src && !S_AXI_AWVALID)[*4] |=> !MASTER_RESET_OUT)
    else $error("master reset without a cause");
  chk_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
    S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
    else $error("write response late");
  chk_read_answer: assert property (ar |=> S_AXI_RVALID)
    else $error("read response late");
  chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID &&
    $stable(S_AXI_RDATA))
    else $error("read data not held");
  chk_unused_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:10] == 22'h0 && !S_AXI_RDATA[5])
    else $error("unused bit read as one");
  chk_trigger_zero: assert property (ar && S_AXI_ARADDR[7:0] == 8'h04 |=> S_AXI_RDATA == 32'h0)
    else $error("trigger read not zero");
  chk_unmapped_err: assert property (ar && S_AXI_ARADDR[7:0] > 8'h14 |=> S_AXI_RRESP == 2'b10)
    else $error("unmapped read not refused");
  cover property (src ##1 MASTER_RESET_OUT);
  cover property (S_AXI_RVALID && S_AXI_RRESP == 2'b10);
  cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule // srcu_props

bind srcu_top srcu_props srcu_props_inst (.*);

// >>> test/srcu_src_model.sv
`timescale 1ns/10ps
// Reset sources and wake lines, one held pulse per request
module srcu_src_model (
  input  wire       clk_in,
  input  wire       go_in,
  input  wire [2:0] sel_in,
  input  wire [2:0] len_in,
  output reg  [5:0] src_out
);
  reg [2:0] cnt_q;
  initial src_out = 6'h00;
  initial cnt_q = 3'h0;
  // Hold the chosen line for len+1 cycles, then release it
  always @(posedge clk_in) begin
    if (go_in) begin
      src_out <= 6'h01 << sel_in;
      cnt_q <= len_in;
    end else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
    else src_out <= 6'h00;
  end
endmodule // srcu_src_model

// >>> test/srcu_top_tb.sv
`timescale 1ns/10ps
`include "srcu_regs.vh"
`define CK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module srcu_top_tb;
  reg         clk = 1'b0, srst = 1'b1, go = 1'b0, saw_m = 1'b0, clr_m = 1'b0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg  [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, d;
  reg  [2:0]  sel = 3'h0, len = 3'h1;
  reg  [1:0]  rsp;
  wire        awready, wready, bvalid, arready, rvalid, mst, vreg, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [5:0]  src;
  integer     failures = 0, compares = 0, i;
  localparam logic [9:0] ST [6] = '{10'h080, 10'h010, 10'h002, 10'h200, 10'h008, 10'h004};
  localparam logic [5:0] MS = 6'h0f;
  always #5 clk = ~clk;
  always @(posedge clk) saw_m <= clr_m ? 1'b0 : (saw_m | mst);
  srcu_src_model srcu_src_model_inst (.clk_in(clk), .go_in(go), .sel_in(sel), .len_in(len),
    .src_out(src));
  srcu_top srcu_top_inst (.REF_CLK_IN(clk), .SRST_IN(srst), .EXTERNAL_CLEAR_PIN_IN(src[0]),
    .WATCHDOG_RESET_SOURCE_IN(src[1]), .BROWNOUT_IN(src[2]), .CONFIG_MISMATCH_IN(src[3]),
    .WAKE_SLEEP_IN(src[4]), .WAKE_IDLE_IN(src[5]), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .MASTER_RESET_OUT(mst), .REGULATOR_STANDBY_ENABLE_OUT(vreg), .IRQ_OUT(irq));
  task wr(input [7:0] a, input [31:0] v);
    @(posedge clk);
    awaddr <= {24'h0, a};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task rd(input [7:0] a, output [31:0] v);
    @(posedge clk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task fire(input [2:0] s, input [2:0] l);
    @(posedge clk);
    sel <= s;
    len <= l;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task unlock;
    wr(`SRCU_OFF_UNLOCK, `SRCU_KEY1);
    wr(`SRCU_OFF_UNLOCK, `SRCU_KEY2);
  endtask
  task report_and_stop;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  initial begin
    #200000;
    failures++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(`SRCU_OFF_STATUS, d); `CK(d, 32'h3)
    wr(`SRCU_OFF_STATUS, 32'h0);
    for (i = 0; i < 6; i++) begin
      fire(i[2:0], i[2:0] + 3'h1);
      repeat (2) @(posedge clk);
      `CK(mst, MS[i])
      repeat (10) @(posedge clk);
      rd(`SRCU_OFF_STATUS, d); `CK(d, {22'h0, ST[i]})
      wr(`SRCU_OFF_STATUS, 32'h0);
      rd(`SRCU_OFF_STATUS, d); `CK(d, 32'h0)
    end
    wr(`SRCU_OFF_STATUS, 32'h100);
    rd(`SRCU_OFF_STATUS, d); `CK(d, 32'h100)
    `CK(vreg, 1'b1)
    wr(`SRCU_OFF_STATUS, 32'h0);
    `CK(vreg, 1'b0)
    clr_m <= 1'b1;
    @(posedge clk);
    clr_m <= 1'b0;
    wr(`SRCU_OFF_SOFT_RESET_TRIGGER_BIT, 32'h1);
    repeat (4) @(posedge clk);
    rd(`SRCU_OFF_STATUS, d); `CK(d, 32'h0)
    `CK(saw_m, 1'b0)
    unlock;
    wr(`SRCU_OFF_SOFT_RESET_TRIGGER_BIT, 32'h0);
    repeat (4) @(posedge clk);
    rd(`SRCU_OFF_STATUS, d); `CK(d, 32'h0)
    wr(`SRCU_OFF_UNLOCK, 32'h0);
    unlock;
    wr(`SRCU_OFF_SOFT_RESET_TRIGGER_BIT, 32'h1);
    repeat (4) @(posedge clk);
    rd(`SRCU_OFF_STATUS, d); `CK(d, 32'h40)
    `CK(saw_m, 1'b1)
    rd(`SRCU_OFF_SOFT_RESET_TRIGGER_BIT, d); `CK(d, 32'h0)
    // Interrupt raise, clear and mask
    wr(`SRCU_OFF_IRQ_CLR, 32'h3ff);
    wr(`SRCU_OFF_IRQ_EN, 32'h10);
    fire(3'h1, 3'h1);
    repeat (12) @(posedge clk);
    `CK(irq, 1'b1)
    wr(`SRCU_OFF_IRQ_CLR, 32'h10);
    repeat (2) @(posedge clk);
    `CK(irq, 1'b0)
    wr(`SRCU_OFF_IRQ_EN, 32'h0);
    fire(3'h1, 3'h2);
    repeat (12) @(posedge clk);
    `CK(irq, 1'b0)
    rd(`SRCU_OFF_IRQ_STAT, d); `CK(d, 32'h10)
    rd(8'h40, d); `CK({rsp, d}, {2'b10, 32'h0})
    wr(8'h40, 32'h1); `CK(rsp, 2'b10)
    // Power-on reset in mid-run
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(`SRCU_OFF_STATUS, d); `CK(d, 32'h3)
    report_and_stop;
  end
endmodule // srcu_top_tb
